// ===== logic/sar_adc_serial_readout.sv
// Frame sequencer and serial result readout of a 16-bit sampling converter
`timescale 1ns/10ps
`default_nettype none

// Function
// R1: Result is unsigned straight binary; larger input gives a larger code.
// R2: Zero input gives 0000, half reference 8000, full scale minus one LSB FFFF.
// R3: Power down after conversion completes and whenever select is high.
// R4: Conversion done with select low: analog off, digital still follows clock.
// R5: Select high shuts digital logic down; serial clock then has no effect.
// R6: Host gives at least 22 serial clocks per frame for a full result.
// R7: Select still low after conversion: result repeats LSB first.
// R8: Each bit appears as decided, so raising select ends conversion early.
// R9: Host should convert at fastest clock and idle with select high.
// R10: One decision per serial clock, output updated in that same cycle.
// R11: Host starts conversions no faster than 100 kHz.
// R12: Select falling starts a frame; bits shift on falling serial clock.
// R13: Five clocks sampling, then low null bit, then 16 bits MSB first.
// R14: After MSB repeated, output goes high impedance, further clocks ignored.
// R15: New conversion only after select goes high then low again.
// R16: Output off while select high; each select fall restarts at sampling.
module sar_adc_serial_readout (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   select_n,
  input  wire logic                   serial_clock,
  output logic                        serial_out,
  output logic                        serial_out_oe,
  input  wire logic                   sample_valid,
  output logic                        sample_ready,
  input  wire logic [15:0]            sample_code,
  output adc_readout_pkg::power_t     power,
  output logic                        rate_fault
);

  // ==========================================================
  // Input edge detection
  logic select_n_q;
  logic sclk_q;
  logic select_fall;
  logic sclk_fall;

  always_ff @(posedge clk) begin
    if (reset) begin
      select_n_q <= 1'b1;
      sclk_q     <= 1'b0;
    end else begin
      select_n_q <= select_n;
      sclk_q     <= serial_clock;
    end
  end

  always_comb begin
    select_fall = select_n_q && !select_n;
    sclk_fall   = sclk_q && !serial_clock;
  end

  // ==========================================================
  // Sample buffer
  logic        buf_valid;
  logic        buf_pop;
  logic [15:0] buf_code;

  sample_fifo #(
    .WIDTH (adc_readout_pkg::FIFO_WIDTH),
    .DEPTH (adc_readout_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_code),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_code)
  );

  // ==========================================================
  // Held analog level, refreshed from the buffer at end of a sampling phase when a sample is waiting
  logic [15:0] level_q, level_d;

  // ==========================================================
  // Bit decisions
  logic        sar_load;
  logic        sar_step;
  logic        sar_bit;
  logic [15:0] sar_result;
  logic [3:0]  bit_idx_q, bit_idx_d;

  sar_decider u_sar (
    .clk          (clk),
    .reset        (reset),
    .load         (sar_load),
    .held_code    (buf_valid ? buf_code : level_q),
    .step         (sar_step),
    .bit_idx      (bit_idx_q),
    .bit_decision (sar_bit),
    .result       (sar_result)
  );

  // ==========================================================
  // Frame sequencer
  adc_readout_pkg::phase_t phase_q, phase_d;
  logic [2:0]              edge_cnt_q, edge_cnt_d;
  logic                    sdo_q, sdo_d;
  logic                    oe_q, oe_d;
  adc_readout_pkg::power_t power_q, power_d;

  always_comb begin
    phase_d    = phase_q;
    edge_cnt_d = edge_cnt_q;
    bit_idx_d  = bit_idx_q;
    sdo_d      = sdo_q;
    oe_d       = oe_q;
    power_d    = power_q;
    level_d    = level_q;
    sar_load   = 1'b0;
    sar_step   = 1'b0;
    buf_pop    = 1'b0;
    if (select_n) begin
      phase_d = adc_readout_pkg::PH_IDLE; // R5
      oe_d    = 1'b0; // R16
      sdo_d   = 1'b0;
      power_d = adc_readout_pkg::POWER_OFF; // R3
    end else begin
      unique case (phase_q)
        adc_readout_pkg::PH_IDLE: begin
          if (select_fall) begin
            phase_d    = adc_readout_pkg::PH_SAMPLE; // R12 R15 R16
            edge_cnt_d = adc_readout_pkg::EDGE_CNT_RST;
            power_d    = '{analog_on: 1'b1, digital_on: 1'b1};
          end
        end
        adc_readout_pkg::PH_SAMPLE: begin
          if (sclk_fall) begin
            edge_cnt_d = 3'(edge_cnt_q + 1'b1);
            if (edge_cnt_d == adc_readout_pkg::SAMPLE_EDGES) begin
              phase_d   = adc_readout_pkg::PH_NULL_BIT; // R13
              oe_d      = 1'b1;
              sdo_d     = 1'b0;
              sar_load  = 1'b1;
              buf_pop   = buf_valid;
              level_d   = buf_valid ? buf_code : level_q;
              bit_idx_d = adc_readout_pkg::BIT_MSB;
            end
          end
        end
        adc_readout_pkg::PH_NULL_BIT, adc_readout_pkg::PH_MSB_FIRST: begin
          if (sclk_fall) begin
            sar_step = 1'b1; // R10
            sdo_d    = sar_bit; // R8 R1 R2
            phase_d  = adc_readout_pkg::PH_MSB_FIRST;
            if (phase_q == adc_readout_pkg::PH_NULL_BIT) begin
              bit_idx_d = 4'(bit_idx_q - 1'b1);
            end else if (bit_idx_q == adc_readout_pkg::BIT_LSB) begin
              phase_d          = adc_readout_pkg::PH_LSB_FIRST;
              power_d.analog_on = 1'b0; // R4 R3
              bit_idx_d        = adc_readout_pkg::BIT_REPEAT0;
            end else begin
              bit_idx_d = 4'(bit_idx_q - 1'b1);
            end
          end
        end
        adc_readout_pkg::PH_LSB_FIRST: begin
          if (sclk_fall) begin
            sdo_d = sar_result[bit_idx_q]; // R7
            if (bit_idx_q == adc_readout_pkg::BIT_MSB) begin
              phase_d = adc_readout_pkg::PH_DONE;
            end else begin
              bit_idx_d = 4'(bit_idx_q + 1'b1);
            end
          end
        end
        adc_readout_pkg::PH_DONE: begin
          if (sclk_fall) begin
            oe_d  = 1'b0; // R14
            sdo_d = 1'b0;
          end
        end
        default: begin
          phase_d = adc_readout_pkg::PH_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  // NULL_BIT step decides bit 15 while index still points at it
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q    <= adc_readout_pkg::PH_IDLE;
      edge_cnt_q <= adc_readout_pkg::EDGE_CNT_RST;
      bit_idx_q  <= adc_readout_pkg::BIT_MSB;
      sdo_q      <= 1'b0;
      oe_q       <= 1'b0;
      power_q    <= adc_readout_pkg::POWER_OFF;
      level_q    <= adc_readout_pkg::CODE_ZERO;
    end else begin
      phase_q    <= phase_d;
      edge_cnt_q <= edge_cnt_d;
      bit_idx_q  <= bit_idx_d;
      sdo_q      <= sdo_d;
      oe_q       <= oe_d;
      power_q    <= power_d;
      level_q    <= level_d;
    end
  end

  // ==========================================================
  // Throughput watch: frame started too soon after the last one
  logic [11:0] frame_cnt_q, frame_cnt_d;
  logic        fault_q, fault_d;
  logic        started_q, started_d;

  always_comb begin
    frame_cnt_d = frame_cnt_q;
    fault_d     = fault_q;
    started_d   = started_q;
    if (frame_cnt_q != adc_readout_pkg::FRAME_CNT_LIMIT) begin
      frame_cnt_d = 12'(frame_cnt_q + 1'b1);
    end
    if (select_fall) begin
      frame_cnt_d = adc_readout_pkg::FRAME_CNT_RST;
      started_d   = 1'b1;
      fault_d     = started_q
                    && (frame_cnt_q < adc_readout_pkg::FRAME_CNT_LIMIT); // R11
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_cnt_q <= adc_readout_pkg::FRAME_CNT_RST;
      fault_q     <= 1'b0;
      started_q   <= 1'b0;
    end else begin
      frame_cnt_q <= frame_cnt_d;
      fault_q     <= fault_d;
      started_q   <= started_d;
    end
  end

  assign serial_out    = sdo_q;
  assign serial_out_oe = oe_q;
  assign power         = power_q;
  assign rate_fault    = fault_q;

endmodule

`default_nettype wire

// ===== logic/adc_readout_pkg.sv
// Shared constants, state encoding and carrier types for the serial converter readout
package adc_readout_pkg;

  // ==========================================================
  // Result format
  localparam int          RESULT_BITS = 16;
  localparam logic [15:0] CODE_ZERO   = 16'h0000;
  localparam logic [15:0] CODE_MID    = 16'h8000;
  localparam logic [15:0] CODE_FULL   = 16'hFFFF;
  localparam logic [3:0]  BIT_MSB     = 4'hF;
  localparam logic [3:0]  BIT_LSB     = 4'h0;
  localparam logic [3:0]  BIT_REPEAT0 = 4'h1;

  // ==========================================================
  // Frame sequencing, in falling serial clock edges
  localparam logic [2:0]  SAMPLE_EDGES = 3'h5;
  localparam logic [2:0]  EDGE_CNT_RST = 3'h0;

  // ==========================================================
  // Sample buffer
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS     = 5;
  localparam int          MIN_FRAME_NS      = 10000;
  localparam int          MIN_FRAME_CYCLES  = (MIN_FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] FRAME_CNT_LIMIT   = 12'(MIN_FRAME_CYCLES);
  localparam logic [11:0] FRAME_CNT_RST     = 12'h000;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    PH_IDLE      = 3'b000,
    PH_SAMPLE    = 3'b001,
    PH_NULL_BIT  = 3'b010,
    PH_MSB_FIRST = 3'b011,
    PH_LSB_FIRST = 3'b100,
    PH_DONE      = 3'b101
  } phase_t;

  typedef struct packed {
    logic analog_on;
    logic digital_on;
  } power_t;

  localparam power_t POWER_OFF = '{analog_on: 1'b0, digital_on: 1'b0};

endpackage

// ===== logic/sample_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             ready_q, ready_d;
  logic             push, pop;

  // ==========================================================
  // Pointer and count update
  always_comb begin
    push    = in_valid && ready_q;
    pop     = out_ready && (cnt_q != '0);
    wr_d    = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d    = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d   = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
    ready_d = cnt_d != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  assign in_ready  = ready_q;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];

endmodule

`default_nettype wire

// ===== logic/sar_decider.sv
// Successive-approximation bit decider against a held sample code
`timescale 1ns/10ps
`default_nettype none

module sar_decider (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic [15:0] held_code,
  input  wire logic        step,
  input  wire logic [3:0]  bit_idx,
  output logic             bit_decision,
  output logic      [15:0] result
);

  logic [15:0] held_q, held_d;
  logic [15:0] res_q, res_d;
  logic [15:0] trial;

  // ==========================================================
  // One trial per step; larger input gives larger code
  always_comb begin
    trial        = res_q | (16'h0001 << bit_idx);
    bit_decision = held_q >= trial;
    held_d       = held_q;
    res_d        = res_q;
    if (load) begin
      held_d = held_code;
      res_d  = adc_readout_pkg::CODE_ZERO;
    end else if (step && bit_decision) begin
      res_d = trial;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      held_q <= adc_readout_pkg::CODE_ZERO;
      res_q  <= adc_readout_pkg::CODE_ZERO;
    end else begin
      held_q <= held_d;
      res_q  <= res_d;
    end
  end

  assign result = res_q;

endmodule

`default_nettype wire

// ===== bench/sar_adc_serial_readout_props.sv
// Port checker for the serial converter readout
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_readout_props (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    select_n,
  input  wire logic                    serial_clock,
  input  wire logic                    serial_out,
  input  wire logic                    serial_out_oe,
  input  wire adc_readout_pkg::power_t power,
  input  wire logic                    rate_fault
);
  logic       sclk_q;
  logic [5:0] falls_q;
  logic       fall;
  // Falling serial clock seen inside a frame
  assign fall = sclk_q & ~serial_clock & ~select_n;
  always_ff @(posedge clk) begin
    sclk_q  <= serial_clock;
    falls_q <= (reset | select_n) ? 6'h00 : falls_q + 6'(fall && falls_q != 6'h3F);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Assertions
  chk_idle_off: assert property (select_n [*2] |=> !serial_out_oe && !serial_out
    && power == 2'b00) else $error("outputs active while deselected");
  chk_power_up: assert property ($fell(select_n) |-> ##2 power == 2'b11)
    else $error("power not on after select fall");
  chk_oe_start: assert property ($rose(serial_out_oe) |-> falls_q == 6'h05
    && ($past(fall) || $past(fall, 2))) else $error("output enabled off the fifth fall");
  chk_null_low: assert property ($rose(serial_out_oe) |-> !serial_out)
    else $error("null bit not low");
  chk_bit_hold: assert property (serial_out_oe && $past(serial_out_oe) && !$past(fall)
    && !$past(fall, 2) |-> $stable(serial_out)) else $error("data moved without a fall");
  chk_tri_count: assert property ($fell(serial_out_oe) && !$past(select_n)
    |-> falls_q == 6'h25) else $error("tristate not at fall 37");
  chk_stay_tri: assert property (falls_q > 6'h25 |-> !serial_out_oe)
    else $error("output back on after tristate");
  chk_analog_on: assert property (!select_n && falls_q inside {[6'h01:6'h14]}
    |-> power == 2'b11) else $error("power dropped mid conversion");
  chk_analog_off: assert property (!select_n && falls_q >= 6'h16 |-> power == 2'b01)
    else $error("analog not off after conversion");
  // ==========================================================
  // Coverage
  cov_full: cover property ($fell(serial_out_oe) && !$past(select_n));
  cov_short: cover property (serial_out_oe && select_n);
  cov_rate: cover property ($rose(rate_fault));
endmodule
bind sar_adc_serial_readout sar_adc_serial_readout_props chk (.clk(clk), .reset(reset),
  .select_n(select_n), .serial_clock(serial_clock), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .power(power), .rate_fault(rate_fault));
`default_nettype wire

// ===== bench/adc_host_model.sv
// Host model: drives select and serial clock, captures data on rising clock
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
  input  wire logic       clk,
  input  wire logic       serial_out,
  input  wire logic       serial_out_oe,
  input  wire logic [1:0] power,
  output var  logic       select_n,
  output var  logic       serial_clock
);
  logic       rx_d [0:63];
  logic       rx_e [0:63];
  logic [1:0] rx_p [0:63];
  initial begin
    select_n     = 1'b1;
    serial_clock = 1'b0;
  end
  // One frame of n clocks, then idle with select high
  task automatic frame(input int n, input int gap);
    select_n <= 1'b0;
    @(posedge clk);
    for (int i = 1; i <= n; i++) begin
      serial_clock <= 1'b1;
      rx_d[i] = serial_out;
      rx_e[i] = serial_out_oe;
      rx_p[i] = power;
      repeat (3) @(posedge clk);
      serial_clock <= 1'b0;
      repeat (3) @(posedge clk);
    end
    select_n <= 1'b1;
    repeat (gap) @(posedge clk);
  endtask
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      serial_clock <= ~serial_clock;
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== bench/sar_adc_serial_readout_tb.sv
// Self-checking bench for the serial converter readout
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_readout_tb;
  typedef struct {logic [15:0] code; logic [15:0] exp;} row_t;
  localparam logic [15:0] L0 = 16'h0000;
  localparam logic [15:0] L1 = 16'h0001;
  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    sample_valid = 1'b0;
  logic [15:0]             sample_code = 16'h0000;
  logic                    select_n;
  logic                    serial_clock;
  logic                    serial_out;
  logic                    serial_out_oe;
  logic                    sample_ready;
  logic                    rate_fault;
  adc_readout_pkg::power_t power;
  int                      err_total = 0;
  int                      n_compared = 0;
  row_t rows [5] = '{'{16'h0000, 16'h0000}, '{16'h8000, 16'h8000},
    '{16'h7FFF, 16'h7FFF}, '{16'hFFFF, 16'hFFFF}, '{16'h1234, 16'h1234}};
  always #2.5 clk = ~clk;
  sar_adc_serial_readout uut (.clk(clk), .reset(reset), .select_n(select_n),
    .serial_clock(serial_clock), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_code(sample_code),
    .power(power), .rate_fault(rate_fault));
  adc_host_model host (.clk(clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .power(power), .select_n(select_n), .serial_clock(serial_clock));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic push(input logic [15:0] c);
    sample_valid <= 1'b1;
    sample_code  <= c;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask
  function automatic logic [15:0] msb_word();
    logic [15:0] w;
    for (int i = 0; i < 16; i++) w[15-i] = host.rx_d[7+i];
    return w;
  endfunction
  // LSB-first stream shares B0 with the end of the MSB-first one
  function automatic logic [15:0] lsb_word();
    logic [15:0] w;
    for (int i = 0; i < 16; i++) w[i] = host.rx_d[22+i];
    return w;
  endfunction
  initial begin
    #480000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("rst_oe", 16'(serial_out_oe), L0);
    check("rst_pwr", 16'(power), L0);
    foreach (rows[r]) begin
      push(rows[r].code);
      host.frame(40, 1900);
      check("msb", msb_word(), rows[r].exp);
      check("lsb", lsb_word(), rows[r].exp);
      check("null", 16'({host.rx_e[6], host.rx_d[6]}), 16'h0002);
      check("smpl_oe", 16'(host.rx_e[5]), L0);
      check("tri", 16'({host.rx_e[38], host.rx_e[40]}), L0);
      check("pwr_on", 16'(host.rx_p[5]), 16'h0003);
      check("pwr_an", 16'(host.rx_p[24]), L1);
    end
    host.idle_clocks(10);
    #1;
    check("idle_oe", 16'(serial_out_oe), L0);
    check("idle_pwr", 16'(power), L0);
    push(16'hA5A5);
    host.frame(12, 1950);
    #1;
    check("short", msb_word() >> 10, 16'h0029);
    check("short_oe", 16'(serial_out_oe), L0);
    host.frame(22, 100);
    host.frame(22, 1900);
    check("rate_hi", 16'(rate_fault), L1);
    host.frame(22, 1900);
    check("rate_lo", 16'(rate_fault), L0);
    sample_valid <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      sample_code <= 16'(i * 16'h0801);
      @(posedge clk);
    end
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("full", 16'(sample_ready), L0);
    sample_valid <= 1'b1;
    sample_code  <= 16'hFFFF;
    repeat (2) @(posedge clk);
    sample_valid <= 1'b0;
    for (int i = 0; i < 33; i++) begin
      host.frame(22, 1900);
      check("drain", msb_word(), 16'((i < 32 ? i : 31) * 16'h0801));
    end
    check("room", 16'(sample_ready), L1);
    close_out();
  end
endmodule
`default_nettype wire
